// ---- ccad_host.sv ----
// partner: host register master and lqi reader
`timescale 1ns/1ps
module ccad_host
(
  input wire logic mclk,
  output logic regWrite = 1'b0,
  output logic regRead = 1'b0,
  output logic [5:0] regAddr = 6'h3F,
  output logic [7:0] regWdata = 8'h00,
  input wire logic [7:0] regRdata,
  input wire logic frameEndEvent,
  input wire logic [7:0] lqiAddr,
  input wire logic [7:0] lqiData
);
  // one access, strobe held one edge; released address and data lines show the inverse of the last value
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge mclk);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
    @(posedge mclk);
    q = regRdata;
  endtask
  // quality is taken only once the frame end event is seen
  task automatic getLqi(output logic [7:0] v, output logic [7:0] a, output logic ok);
    ok = 1'b0;
    repeat (8)
    begin
      @(posedge mclk);
      if (frameEndEvent === 1'b1 && !ok)
      begin
        v = lqiData;
        a = lqiAddr;
        ok = 1'b1;
      end
    end
  endtask
endmodule // ccad_host

// ---- ccad_lqi_acc.sv ----
// module: lqi accumulator over per-symbol correlation results
`timescale 1ns/1ps
module ccad_lqi_acc
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic frameStart,
  input wire logic corrValid,
  input wire logic [7:0] corrValue,
  input wire logic frameEnd,
  input wire logic [7:0] psduLength,
  output logic lqiValid,
  output logic [7:0] lqiValue
);
  import ccad_pkg::*;
  logic [15:0] sum_q, sum_d;
  logic [7:0] cnt_q, cnt_d;
  logic valid_q, valid_d;
  logic [7:0] lqi_q, lqi_d;
  logic [15:0] avg;

  always_comb
  begin
    sum_d = sum_q;
    cnt_d = cnt_q;
    valid_d = 1'b0;
    lqi_d = lqi_q;
    avg = (cnt_q == 8'h00) ? 16'h0000 : sum_q / {8'h00, cnt_q};
    if (frameStart)
    begin
      sum_d = 16'h0000;
      cnt_d = 8'h00;
    end
    else if (corrValid && cnt_q != 8'hFF)
    begin
      // averaging over many symbols R08
      sum_d = sum_q + {8'h00, corrValue}; // R08
      cnt_d = cnt_q + 8'h01;
    end
    if (frameEnd)
    begin
      // short frames give zero, no meaningful quality R10
      lqi_d = (psduLength >= 8'(CCAD_MIN_PSDU)) ? avg[7:0] : 8'h00; // R09
      valid_d = psduLength >= 8'(CCAD_MIN_PSDU); // R10
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sum_q <= 16'h0000;
      cnt_q <= 8'h00;
      valid_q <= 1'b0;
      lqi_q <= 8'h00;
    end
    else
    begin
      sum_q <= sum_d;
      cnt_q <= cnt_d;
      valid_q <= valid_d;
      lqi_q <= lqi_d;
    end
  end

  assign lqiValid = valid_q;
  assign lqiValue = lqi_q;
endmodule // ccad_lqi_acc

// ---- ccad_pkg.sv ----
// package: register map, field layout and timing constants for cca decision and lqi
package ccad_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [5:0] CCAD_STATUS_ADDR = 6'h01;
  localparam logic [5:0] CCAD_CHCTRL_ADDR = 6'h08;
  localparam logic [5:0] CCAD_THRES_ADDR = 6'h09;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CCAD_TRIG_BIT = 7;
  localparam int CCAD_MODE_HI = 6;
  localparam int CCAD_MODE_LO = 5;
  localparam int CCAD_LEVEL_HI = 3;
  localparam int CCAD_LEVEL_LO = 0;
  localparam int CCAD_DONE_BIT = 7;
  localparam int CCAD_IDLE_BIT = 6;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CCAD_CHCTRL_RST = 8'h2B;
  localparam logic [7:0] CCAD_THRES_RST = 8'hC7;
  // ****************************************
  // timing
  // ****************************************
  localparam int CCAD_SYMBOL_NS = 16000;
  localparam int CCAD_CLK_NS = 5;
  localparam int CCAD_SYMBOLS = 8;
  localparam int CCAD_MEAS_CYCLES = (CCAD_SYMBOLS * CCAD_SYMBOL_NS) / CCAD_CLK_NS;
  localparam int CCAD_STEP_DB = 2;
  localparam int CCAD_MIN_PSDU = 2;
  typedef enum logic [2:0]
  {
    CCAD_IDLE = 3'b001,
    CCAD_MEAS = 3'b010,
    CCAD_DONE = 3'b100
  } ccad_state_e;
endpackage

// ---- ccad_props.sv ----
// checker: timing and framing properties on the ccad_top ports
`timescale 1ns/1ps
module ccad_props
#(
  parameter int MEAS_CYCLES = 16
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic rxListening,
  input wire logic frameEnd,
  input wire logic [7:0] psduLength,
  input wire logic [7:0] frameEndAddr,
  input wire logic assessmentDoneEvent,
  input wire logic frameEndEvent,
  input wire logic lqiWrite,
  input wire logic [7:0] lqiAddr
);
  import ccad_pkg::*;
  localparam int LDLY = MEAS_CYCLES + 2;
  logic trig, armD, armQ;
  // ****
  // helper: a trigger counts only when no assessment is pending
  // ****
  assign trig = regWrite && regAddr == CCAD_CHCTRL_ADDR && regWdata[7] && !armQ;
  always_comb armD = trig || (armQ && !assessmentDoneEvent);
  always_ff @(posedge mclk) armQ <= rst_n && armD;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  listenDone_a: assert property (trig && rxListening |-> ##LDLY assessmentDoneEvent)
    else $error("late done event");
  listenQuiet_a: assert property (trig && rxListening |=> !assessmentDoneEvent [*8])
    else $error("early done event");
  offDone_a: assert property (trig && !rxListening |-> ##2 assessmentDoneEvent)
    else $error("done event missing");
  donePulse_a: assert property (assessmentDoneEvent |=> !assessmentDoneEvent)
    else $error("done event too long");
  shortFrame_a: assert property (frameEnd && psduLength < 8'h02 |=> !frameEndEvent)
    else $error("event on short frame");
  longFrame_a: assert property (frameEnd && psduLength > 8'h01 |=> frameEndEvent)
    else $error("frame end event missing");
  lqiPlace_a: assert property (frameEndEvent |-> lqiWrite && lqiAddr == $past(frameEndAddr))
    else $error("lqi write misplaced");
  trigRead_a: assert property (regRead && regAddr == CCAD_CHCTRL_ADDR |=> !regRdata[7])
    else $error("trigger bit reads one");
  cover property (trig && rxListening);
  cover property (frameEnd && psduLength < 8'h02);
  cover property (frameEndEvent);
endmodule // ccad_props
bind ccad_top ccad_props #(.MEAS_CYCLES(MEAS_CYCLES)) props_i (.mclk(mclk), .rst_n(rst_n),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .rxListening(rxListening), .frameEnd(frameEnd),
  .psduLength(psduLength), .frameEndAddr(frameEndAddr),
  .assessmentDoneEvent(assessmentDoneEvent), .frameEndEvent(frameEndEvent),
  .lqiWrite(lqiWrite), .lqiAddr(lqiAddr));

// ---- ccad_top.sv ----
// module: clear channel assessment decision and link quality reporting
// Overview of operation
// R01: mode 0 reports busy when carrier sense or energy says busy.
// R02: mode 1, the reset default, decides from energy comparison only.
// R03: mode 2 decides from carrier sense only.
// R04: mode 3 reports busy only when both say busy.
// R05: mode field sits in bits 6:5 of channel control, read and write.
// R06: energy busy when power exceeds floor plus 2 dB times level; bits 3:0, reset 7.
// R07: modes 0 and 3 reuse the same energy comparison result.
// R08: each frame gets a quality value from correlations over many symbols.
// R09: quality value is unsigned 0 to 255, higher is better.
// R10: valid quality only for payloads of at least two octets.
// R11: quality value available only after frame end event.
// R12: host reads the quality value from the frame buffer after frame end.
// R13: on completion the idle flag is 1 for idle, 0 for busy.
// R14: a trigger write ends with the assessment done event.
// R15: in listening state the assessment spans eight symbol periods.
// R16: the quality value is appended to the stored frame.
`timescale 1ns/1ps
module ccad_top
#(
  parameter int MEAS_CYCLES = ccad_pkg::CCAD_MEAS_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic rxListening,
  input wire logic carrierBusy,
  input wire logic [7:0] powerDbm,
  input wire logic [7:0] signalFloorValue,
  input wire logic frameStart,
  input wire logic corrValid,
  input wire logic [7:0] corrValue,
  input wire logic frameEnd,
  input wire logic [7:0] psduLength,
  input wire logic [7:0] frameEndAddr,
  output logic assessmentDoneEvent,
  output logic frameEndEvent,
  output logic lqiWrite,
  output logic [7:0] lqiAddr,
  output logic [7:0] lqiData
);
  import ccad_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] chctrl_q, chctrl_d;
  logic [7:0] thres_q, thres_d;
  logic done_q, done_d;
  logic idle_q, idle_d;
  logic evt_q, evt_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] busyMode;
  logic [3:0] busyLevel;
  logic energyBusy, channelBusy, trigger;
  logic [8:0] threshold;
  logic [31:0] cnt_q, cnt_d;
  ccad_state_e state_q, state_d;
  logic lqiValid;
  logic [7:0] lqiValue;
  logic [7:0] endAddr_q, endAddr_d;

  function automatic logic cca_decide(input logic [1:0] m, input logic e, input logic c);
    case (m)
      2'h0: cca_decide = e | c; // R01
      2'h1: cca_decide = e; // R02
      2'h2: cca_decide = c; // R03
      default: cca_decide = e & c; // R04
    endcase
  endfunction

  assign busyMode = chctrl_q[CCAD_MODE_HI:CCAD_MODE_LO]; // R05
  assign busyLevel = thres_q[CCAD_LEVEL_HI:CCAD_LEVEL_LO];
  // 9 bits so a high floor plus level cannot wrap into a false busy
  assign threshold = {1'b0, signalFloorValue} + 9'(busyLevel * CCAD_STEP_DB); // R06
  assign energyBusy = {1'b0, powerDbm} > threshold; // R06
  assign channelBusy = cca_decide(busyMode, energyBusy, carrierBusy); // R07
  assign trigger = regWrite && regAddr == CCAD_CHCTRL_ADDR && regWdata[CCAD_TRIG_BIT];

  // ****************************************
  // register access and assessment sequence
  // ****************************************
  always_comb
  begin
    chctrl_d = chctrl_q;
    thres_d = thres_q;
    done_d = done_q;
    idle_d = idle_q;
    evt_d = 1'b0;
    state_d = state_q;
    cnt_d = cnt_q;
    rdata_d = rdata_q;
    if (regWrite && regAddr == CCAD_CHCTRL_ADDR)
    begin
      // trigger bit self-clears, reads always zero
      chctrl_d = {1'b0, regWdata[6:0]}; // R05
    end
    if (regWrite && regAddr == CCAD_THRES_ADDR)
    begin
      thres_d = regWdata;
    end
    case (state_q)
      CCAD_IDLE:
      begin
        if (trigger)
        begin
          done_d = 1'b0;
          idle_d = 1'b0;
          cnt_d = 32'h0;
          // outside listening no measurement runs, but done still fires
          state_d = rxListening ? CCAD_MEAS : CCAD_DONE; // R15
        end
      end
      CCAD_MEAS:
      begin
        if (channelBusy)
        begin
          idle_d = 1'b0;
        end
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(MEAS_CYCLES - 1))
        begin
          // keep the running result so a quiet last sample cannot hide an earlier busy one
          state_d = CCAD_DONE; // R15
        end
        if (cnt_q == 32'h0)
        begin
          idle_d = 1'b1;
        end
      end
      CCAD_DONE:
      begin
        done_d = 1'b1;
        evt_d = 1'b1; // R14
        state_d = CCAD_IDLE;
      end
      default: state_d = CCAD_IDLE;
    endcase
    if (state_q == CCAD_MEAS && channelBusy)
    begin
      // any busy sample during the window marks the channel busy
      idle_d = 1'b0; // R13
    end
    if (regRead)
    begin
      case (regAddr)
        CCAD_STATUS_ADDR: rdata_d = {done_q, idle_q, 6'h00}; // R13
        CCAD_CHCTRL_ADDR: rdata_d = chctrl_q;
        CCAD_THRES_ADDR: rdata_d = thres_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      chctrl_q <= CCAD_CHCTRL_RST;
      thres_q <= CCAD_THRES_RST;
      done_q <= 1'b0;
      idle_q <= 1'b0;
      evt_q <= 1'b0;
      state_q <= CCAD_IDLE;
      cnt_q <= 32'h0;
      rdata_q <= 8'h00;
    end
    else
    begin
      chctrl_q <= chctrl_d;
      thres_q <= thres_d;
      done_q <= done_d;
      idle_q <= idle_d;
      evt_q <= evt_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // link quality
  // ****************************************
  ccad_lqi_acc u_lqi
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .frameStart(frameStart),
    .corrValid(corrValid),
    .corrValue(corrValue),
    .frameEnd(frameEnd),
    .psduLength(psduLength),
    .lqiValid(lqiValid),
    .lqiValue(lqiValue)
  );

  always_comb
  begin
    endAddr_d = frameEnd ? frameEndAddr : endAddr_q;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      endAddr_q <= 8'h00;
    end
    else
    begin
      endAddr_q <= endAddr_d;
    end
  end

  // the value lands in the buffer the same cycle the end event fires, so any read after it sees it
  assign lqiWrite = lqiValid; // R16
  assign lqiAddr = endAddr_q; // R16
  assign lqiData = lqiValue; // R09
  assign frameEndEvent = lqiValid; // R11 R12
  assign assessmentDoneEvent = evt_q; // R14
  assign regRdata = rdata_q;
endmodule // ccad_top

// ---- testbench.sv ----
// testbench: register, assessment and lqi scenarios for ccad_top
`timescale 1ns/1ps
module testbench;
  import ccad_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, rxListening = 1'b1, carrierBusy = 1'b0;
  logic frameStart = 1'b0, corrValid = 1'b0, frameEnd = 1'b0;
  logic [7:0] powerDbm = 8'h00, signalFloorValue = 8'h40, corrValue = 8'h00;
  logic [7:0] psduLength = 8'h00, frameEndAddr = 8'h00;
  logic regWrite, regRead, assessmentDoneEvent, frameEndEvent, lqiWrite;
  logic [5:0] regAddr;
  logic [7:0] regWdata, regRdata, lqiAddr, lqiData, q;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int nWrites = 0;
  always @(posedge mclk)
  begin
    if (lqiWrite === 1'b1)
      nWrites <= nWrites + 1;
  end
  always #2.5 mclk = ~mclk;
  // short window keeps seventeen assessments cheap
  ccad_top #(.MEAS_CYCLES(16)) uut (.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .rxListening(rxListening), .carrierBusy(carrierBusy), .powerDbm(powerDbm),
    .signalFloorValue(signalFloorValue), .frameStart(frameStart), .corrValid(corrValid),
    .corrValue(corrValue), .frameEnd(frameEnd), .psduLength(psduLength),
    .frameEndAddr(frameEndAddr), .assessmentDoneEvent(assessmentDoneEvent),
    .frameEndEvent(frameEndEvent), .lqiWrite(lqiWrite), .lqiAddr(lqiAddr), .lqiData(lqiData));
  ccad_host host (.mclk(mclk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .frameEndEvent(frameEndEvent),
    .lqiAddr(lqiAddr), .lqiData(lqiData));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      $display("ERROR %0t timeout", $time);
      end_sim();
    end
  end
  task automatic assess(input logic [1:0] m, input logic [7:0] expSt);
    host.acc(1'b1, CCAD_CHCTRL_ADDR, {1'b1, m, 5'h0B}, q);
    for (int i = 0; i < 40 && assessmentDoneEvent !== 1'b1; i++)
      @(posedge mclk);
    chk({7'h00, assessmentDoneEvent}, 8'h01);
    host.acc(1'b0, CCAD_STATUS_ADDR, 8'h00, q);
    chk(q, expSt);
    host.acc(1'b0, CCAD_CHCTRL_ADDR, 8'h00, q);
    chk(q, {1'b0, m, 5'h0B});
  endtask
  task automatic modeTable();
    logic busy;
    host.acc(1'b0, CCAD_THRES_ADDR, 8'h00, q);
    chk(q, 8'hC7);
    host.acc(1'b1, CCAD_THRES_ADDR, 8'hC3, q);
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 4; k++)
      begin
        carrierBusy <= k[0];
        // floor 0x40 plus 2 dB times 3; only strictly above counts as busy
        powerDbm <= 8'h46 + 8'(k[1]);
        busy = m == 0 ? k[0] | k[1] : m == 1 ? k[1] : m == 2 ? k[0] : k[0] & k[1];
        assess(2'(m), {1'b1, !busy, 6'h00});
      end
  endtask
  task automatic busyBlip();
    carrierBusy <= 1'b0;
    powerDbm <= 8'h00;
    fork
      assess(2'h2, 8'h80);
      begin
        // one busy sample in mid-window must leave the channel busy
        repeat (8) @(posedge mclk);
        carrierBusy <= 1'b1;
        @(posedge mclk);
        carrierBusy <= 1'b0;
      end
    join
  endtask
  task automatic offState();
    rxListening <= 1'b0;
    host.acc(1'b1, CCAD_CHCTRL_ADDR, 8'hA0, q);
    @(posedge mclk);
    chk({7'h00, assessmentDoneEvent}, 8'h01);
    host.acc(1'b0, CCAD_STATUS_ADDR, 8'h00, q);
    chk(q & 8'h80, 8'h80);
    rxListening <= 1'b1;
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] len,
    input logic [7:0] expV, input logic expOk);
    logic [7:0] v, ad;
    logic ok;
    int w0;
    w0 = nWrites;
    @(posedge mclk);
    frameStart <= 1'b1;
    @(posedge mclk);
    frameStart <= 1'b0;
    corrValid <= 1'b1;
    corrValue <= a;
    @(posedge mclk);
    corrValue <= b;
    @(posedge mclk);
    corrValid <= 1'b0;
    corrValue <= ~b;
    frameEnd <= 1'b1;
    psduLength <= len;
    frameEndAddr <= len + 8'h10;
    @(posedge mclk);
    frameEnd <= 1'b0;
    psduLength <= ~len;
    frameEndAddr <= ~len;
    host.getLqi(v, ad, ok);
    chk({7'h00, ok}, {7'h00, expOk});
    if (expOk)
    begin
      chk(v, expV);
      chk(ad, len + 8'h10);
    end
    chk(8'(nWrites - w0), {7'h00, expOk});
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    host.acc(1'b0, CCAD_CHCTRL_ADDR, 8'h00, q);
    chk(q, 8'h2B);
    modeTable();
    busyBlip();
    offState();
    frame(8'h0A, 8'h1E, 8'h05, 8'h14, 1'b1);
    frame(8'hFF, 8'hFD, 8'h7F, 8'hFE, 1'b1);
    frame(8'h10, 8'h30, 8'h02, 8'h20, 1'b1);
    frame(8'h20, 8'h20, 8'h01, 8'h00, 1'b0);
    end_sim();
  end
endmodule // testbench
